// ### rtl/buck_seq_prot.sv
// Sequencing, switch control, protection and AXI4-Lite registers of the buck regulator
//
// Functional notes
// - Soft start begins only with internal supply at 4.2V and enable high.
// - Regulation-good asserts 4ms after soft-start entry.
// - Target follows ramp below initial setpoint, then the fixed reference; the code ramps to the selected setpoint (pin or code) and holds it.
// - Discharge path on with input power present and enable low.
// - Fire on-pulse when setpoint exceeds feedback; width inverse to input voltage.
// - Enforce 300ns minimum off time after every on-pulse; the off timer is not loaded when overvoltage ends a pulse early.
// - Over current limit keeps low side on and blocks new on-pulses.
// - Current limit for 16 switching cycles turns both off and latches; blocked on-pulses keep the count at 1 or less, so it never trips.
// - Only an enable retrigger clears the latched-off state.
// - Output under 70% of target for 32us turns both off, latches.
// - Output above setpoint by 20% forces low side on until below.
// - 7-bit code maps 0.6V plus 9.375mV per step.
// - At power-up the setpoint comes from the initial-setpoint pin.
// - Control bit selects pin (default) or programmed code for setpoint.
// - Protection-mode bit: 0 auto-recovery, 1 latch-off, resets to latch-off.
// - Voltage-change bit suppresses protection while a new code settles.
// - Programmed setpoint code resets to 0110010.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module buck_seq_prot
   import buck_ctrl_pkg::*;
#(
   parameter int REGULATION_GOOD_FLAG_CYC = REGULATION_GOOD_FLAG_DELAY_CYC,
   parameter int RETRY_CYC = RETRY_WAIT_CYC,
   parameter int ONTIME_K = 2000
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic enable,
   input wire logic vin_present,
   input wire logic vcc_ok,
   input wire logic [20:0] initial_setpoint_pin,
   input wire logic [20:0] output_sense_and_code,
   input wire logic [20:0] ripple_sense,
   input wire logic [7:0] vin_volts,
   input wire logic low_side_over_limit,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic high_side_on,
   output logic low_side_on,
   output logic discharge_on,
   output logic regulation_good_flag,
   output logic overvoltage_clamp,
   output logic light_load_pulse_skip_select,
   output logic irq
);
   seq_state_type state_r, state_nxt;
   logic [6:0] voltage_id_code_r;
   logic [7:0] ctrl_r;
   logic [EV_W-1:0] irq_st_r, irq_mask_r, ev;
   logic enable_d_r, en_rise;
   logic [20:0] ramp_r, target_r, setpt, fixed_ref;
   logic [20:0] ss_cnt_r;
   logic on_r, off_r, on_load, off_load, on_done, off_done;
   logic [4:0] oc_cycles_r;
   logic uv_cond, ov_r, good_done, uv_done, retry_done, fault, prot_quiet_r;
   logic [15:0] on_cnt;
   logic wr_go, rd_go;
   logic [7:0] awaddr_r, araddr_r;
   logic aw_have_r, w_have_r;
   logic [31:0] wdata_r;
   logic [31:0] rd_val;

   assign en_rise = enable && !enable_d_r;
   // Setpoint source: programmed code or pin divider
   assign fixed_ref = SETPT_BASE_UV + SETPT_STEP_UV * {14'h0_000, voltage_id_code_r};
   assign setpt = ctrl_r[CTRL_SRC_BIT] ? fixed_ref : initial_setpoint_pin;
   assign uv_cond = (output_sense_and_code * 10) < (target_r * 7);
   assign fault = state_r == ST_RUN && !prot_quiet_r && (uv_done || oc_cycles_r >= 5'(OC_CYCLE_LIMIT));
   assign on_cnt = 16'(ONTIME_K / ((vin_volts == 8'h00) ? 1 : int'(vin_volts)));

   // Enable edge detect (inputs synchronous)
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_d_r <= 1'b0;
      end else if (ce) begin
         enable_d_r <= enable;
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: if (enable && vcc_ok) state_nxt = ST_SOFT;
         ST_SOFT, ST_RUN: begin
            if (!enable) state_nxt = ST_OFF;
            else if (fault) state_nxt = ctrl_r[CTRL_PROT_BIT] ? ST_LATCHED : ST_RETRY;
            else if (state_r == ST_SOFT && good_done) state_nxt = ST_RUN;
         end
         ST_LATCHED: if (!enable) state_nxt = ST_OFF;
         ST_RETRY: begin
            if (!enable) state_nxt = ST_OFF;
            else if (retry_done) state_nxt = ST_SOFT;
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   // Sequencer state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_OFF;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // Fault checks run only in the run state, not during soft start
   // Regulation-good timer from soft-start entry
   cycle_timer #(.W(32)) good_tmr (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .load(state_r != ST_SOFT && state_nxt == ST_SOFT), .count(32'(REGULATION_GOOD_FLAG_CYC)),
      .run(state_r == ST_SOFT), .done(good_done)
   );
   cycle_timer #(.W(16)) uv_tmr (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .load(!uv_cond || state_r != ST_RUN), .count(16'(UV_DELAY_CYC)),
      .run(uv_cond), .done(uv_done)
   );
   cycle_timer #(.W(32)) retry_tmr (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .load(state_r != ST_RETRY), .count(32'(RETRY_CYC)),
      .run(1'b1), .done(retry_done)
   );
   cycle_timer #(.W(16)) on_tmr (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .load(on_load), .count(on_cnt - 16'h0001), .run(on_r), .done(on_done)
   );
   cycle_timer #(.W(16)) off_tmr (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .load(off_load), .count(16'(MIN_OFF_CYC)), .run(off_r), .done(off_done)
   );

   // Soft-start ramp and regulation target
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ramp_r <= '0;
         ss_cnt_r <= '0;
         target_r <= '0;
      end else if (ce) begin
         if (state_r != ST_SOFT && state_r != ST_RUN) begin
            ramp_r <= '0;
            ss_cnt_r <= '0;
            target_r <= '0;
         end else begin
            ss_cnt_r <= (ss_cnt_r == 21'(SS_STEP_CYC - 1)) ? '0 : ss_cnt_r + 1'b1;
            if (ss_cnt_r == 21'(SS_STEP_CYC - 1) && ramp_r <= setpt) begin
               ramp_r <= ramp_r + {7'h00, SS_STEP_UV};
            end
            target_r <= (ramp_r < setpt) ? ramp_r : setpt;
         end
      end
   end

   // Pulse engine: one-shot on, minimum off, current limit and overvoltage override
   assign on_load = (state_r == ST_SOFT || state_r == ST_RUN) && !on_r && !off_r
      && !low_side_over_limit && !ov_r
      && (target_r > output_sense_and_code + ripple_sense);
   assign off_load = on_r && on_done;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         on_r <= 1'b0;
         off_r <= 1'b0;
      end else if (ce) begin
         if (state_nxt != ST_SOFT && state_nxt != ST_RUN) begin
            on_r <= 1'b0;
            off_r <= 1'b0;
         end else if (on_load) begin
            on_r <= 1'b1;
         end else if (off_load || (on_r && ov_r)) begin
            on_r <= 1'b0;
            off_r <= 1'b1;
         end else if (off_r && off_done) begin
            off_r <= 1'b0;
         end
      end
   end

   // Overvoltage clamp with hysteresis down to the setpoint
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ov_r <= 1'b0;
      end else if (ce) begin
         if (state_r != ST_SOFT && state_r != ST_RUN) ov_r <= 1'b0;
         else if (output_sense_and_code * 5 > setpt * 6) ov_r <= 1'b1;
         else if (output_sense_and_code < setpt) ov_r <= 1'b0;
      end
   end

   // Over-current switching cycle counter, counted when an on-pulse times out while over the limit (not when overvoltage ends it)
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oc_cycles_r <= '0;
      end else if (ce) begin
         if (state_r != ST_RUN && state_r != ST_SOFT) oc_cycles_r <= '0;
         else if (!low_side_over_limit) oc_cycles_r <= '0;
         else if (off_load && oc_cycles_r < 5'(OC_CYCLE_LIMIT)) oc_cycles_r <= oc_cycles_r + 1'b1;
      end
   end

   // Protection quiet window while a new code settles
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prot_quiet_r <= 1'b0;
      end else if (ce) begin
         if (ctrl_r[CTRL_VCHG_BIT] && wr_go && awaddr_r == ADDR_CODE) prot_quiet_r <= 1'b1;
         else if (target_r == setpt && !uv_cond) prot_quiet_r <= 1'b0;
      end
   end

   // Pin outputs, all registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         high_side_on <= 1'b0;
         low_side_on <= 1'b0;
         discharge_on <= 1'b0;
         regulation_good_flag <= 1'b0;
         overvoltage_clamp <= 1'b0;
         light_load_pulse_skip_select <= 1'b1;
      end else if (ce) begin
         high_side_on <= on_r && !ov_r;
         low_side_on <= (state_r == ST_SOFT || state_r == ST_RUN) && (!on_r || ov_r);
         discharge_on <= vin_present && !enable;
         regulation_good_flag <= state_nxt == ST_RUN;
         overvoltage_clamp <= ov_r;
         light_load_pulse_skip_select <= ctrl_r[CTRL_SKIP_BIT];
      end
   end

   // Event sources; set wins over write-one-to-clear
   assign ev[EV_OC] = off_load && low_side_over_limit;
   assign ev[EV_UV] = fault && uv_done;
   assign ev[EV_OV] = ov_r && !overvoltage_clamp;
   assign ev[EV_GOOD] = state_r == ST_SOFT && state_nxt == ST_RUN;
   assign ev[EV_LATCH] = state_r != ST_LATCHED && state_nxt == ST_LATCHED;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_st_r <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         irq_st_r <= (irq_st_r & ~((wr_go && awaddr_r == ADDR_IRQ_ST) ? wdata_r[EV_W-1:0] : '0)) | ev;
         irq <= |(irq_st_r & irq_mask_r);
      end
   end

   // AXI4-Lite write channel capture, either order
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
               {8{s_axi_wstrb[0]}}};
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r <= ADDR_IRQ_MASK && awaddr_r[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Writable registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         voltage_id_code_r <= CODE_RESET;
         ctrl_r <= CTRL_RESET;
         irq_mask_r <= '0;
      end else if (ce && wr_go) begin
         unique case (awaddr_r)
            ADDR_CODE: voltage_id_code_r <= wdata_r[6:0];
            ADDR_CTRL: ctrl_r <= wdata_r[7:0];
            ADDR_IRQ_MASK: irq_mask_r <= wdata_r[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Read mux
   always_comb begin
      rd_val = '0;
      unique case (araddr_r)
         ADDR_CODE: rd_val = {25'h0, voltage_id_code_r};
         ADDR_CTRL: rd_val = {24'h0, ctrl_r};
         ADDR_STATUS: rd_val = {24'h0, ov_r, regulation_good_flag, oc_cycles_r[4], prot_quiet_r, state_r, 1'b0};
         ADDR_IRQ_ST: rd_val = {27'h0, irq_st_r};
         ADDR_IRQ_MASK: rd_val = {27'h0, irq_mask_r};
         default: rd_val = '0;
      endcase
   end

   // AXI4-Lite read channel: address taken, data one cycle later
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         araddr_r <= '0;
         rd_go <= 1'b0;
      end else if (ce) begin
         rd_go <= s_axi_arvalid && s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            araddr_r <= s_axi_araddr;
            s_axi_arready <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (araddr_r <= ADDR_IRQ_MASK && araddr_r[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checks
   a_start_needs_vcc: assert property (@(posedge core_clk) disable iff (rst)
      ce && state_r == ST_OFF && state_nxt == ST_SOFT |-> enable && vcc_ok)
      else $error("soft start without enable and supply");
   a_discharge_follows: assert property (@(posedge core_clk) disable iff (rst)
      ce |=> discharge_on == $past(vin_present && !enable))
      else $error("discharge path wrong");
   a_no_fire_over_limit: assert property (@(posedge core_clk) disable iff (rst)
      low_side_over_limit |-> !on_load)
      else $error("on-pulse during current limit");
   a_min_off_time: assert property (@(posedge core_clk) disable iff (rst)
      ce && on_r && !on_load ##1 !on_r |-> !on_r [*3])
      else $error("off time too short");
   a_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
      state_r == ST_LATCHED && enable |=> state_r == ST_LATCHED)
      else $error("latch cleared without enable");
   a_switch_exclusive: assert property (@(posedge core_clk) disable iff (rst)
      !(high_side_on && low_side_on))
      else $error("both switches on");
   a_ov_clamp_low: assert property (@(posedge core_clk) disable iff (rst)
      ce && ov_r && state_r == ST_RUN |=> !high_side_on)
      else $error("high side on under overvoltage");
   a_code_reset: assert property (@(posedge core_clk)
      $fell(rst) |-> voltage_id_code_r == CODE_RESET)
      else $error("code reset value wrong");
endmodule

// ### rtl/buck_ctrl_pkg.sv
// Shared constants for the step-down regulator sequencing and protection control
package buck_ctrl_pkg;
   localparam int CLK_MHZ = 100;
   // Timing figures in their own units and derived cycle counts
   localparam int REGULATION_GOOD_FLAG_DELAY_US = 4000;
   localparam int REGULATION_GOOD_FLAG_DELAY_CYC = REGULATION_GOOD_FLAG_DELAY_US * CLK_MHZ;
   localparam int MIN_OFF_NS = 300;
   localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
   localparam int UV_DELAY_US = 32;
   localparam int UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;
   localparam int OC_CYCLE_LIMIT = 16;
   localparam int RETRY_WAIT_CYC = 4000;
   localparam int SS_STEP_CYC = 16;
   // Setpoint code mapping: millivolt times 1000 (microvolts)
   localparam int CODE_W = 7;
   localparam int SETPT_W = 21;
   localparam logic [20:0] SETPT_BASE_UV = 21'h09_27C0;
   localparam logic [20:0] SETPT_STEP_UV = 21'h0_249F;
   localparam logic [6:0] CODE_RESET = 7'h32;
   localparam logic [13:0] SS_STEP_UV = 14'h0_3E8;
   // Register byte addresses
   localparam logic [7:0] ADDR_CODE = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // Control field positions and reset values
   localparam int CTRL_PROT_BIT = 0;
   localparam int CTRL_SKIP_BIT = 3;
   localparam int CTRL_VCHG_BIT = 4;
   localparam int CTRL_SRC_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h09;
   // Event bits
   localparam int EV_OC = 0;
   localparam int EV_UV = 1;
   localparam int EV_OV = 2;
   localparam int EV_GOOD = 3;
   localparam int EV_LATCH = 4;
   localparam int EV_W = 5;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_SOFT = 3'b001,
      ST_RUN = 3'b010,
      ST_LATCHED = 3'b011,
      ST_RETRY = 3'b100
   } seq_state_type;
endpackage

// ### rtl/cycle_timer.sv
// Loadable down-counter with done flag, used for the good, undervoltage, retry, on and off intervals
`timescale 1ns/1ps
module cycle_timer #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] count,
   input wire logic run,
   output logic done
);
   logic [W-1:0] cnt_r;
   // Counts down while run is high; done once it reaches zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_r <= count;
         end else if (run && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
   assign done = (cnt_r == '0) && !load;
endmodule

// ### testbench/power_stage_model.sv
// Power-stage stand-in: sensed output, ripple feedback and a shoot-through watch
`timescale 1ns/1ps
module power_stage_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic high_side_on,
   input wire logic low_side_on,
   input wire logic [20:0] level,
   output logic [20:0] output_sense_and_code,
   output logic [20:0] ripple_sense,
   output logic overlap_seen
);
   // Output follows the commanded level one cycle late; ripple climbs while the low side conducts
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         output_sense_and_code <= '0;
         ripple_sense <= '0;
         overlap_seen <= 1'b0;
      end else begin
         output_sense_and_code <= level;
         if (high_side_on) begin
            ripple_sense <= '0;
         end else if (low_side_on && ripple_sense < 21'h0_00FF) begin
            ripple_sense <= ripple_sense + 21'h0_0001;
         end
         if (high_side_on && low_side_on) begin
            overlap_seen <= 1'b1; // Both switches on would short the input
         end
      end
   end
endmodule

// ### testbench/buck_sequencing_protection_ctrl_bench.sv
// Self-checking bench for the regulator sequencing and protection block
`timescale 1ns/1ps
module buck_sequencing_protection_ctrl_bench;
   import buck_ctrl_pkg::*;
   localparam int PG = 200;
   localparam int RT = 50;
   localparam int OK = 200;
   localparam logic [20:0] PIN = 21'h0A_AE60;
   localparam logic [20:0] NORM = 21'h08_8B80;
   localparam logic [20:0] LOW = 21'h06_68A0;
   logic core_clk = 0, rst = 1, ce = 1, enable = 0, vin_present = 1, vcc_ok = 0;
   logic low_side_over_limit = 0, hs_d = 0;
   logic [7:0] vin_volts = 8'h14, s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [20:0] level = NORM, initial_setpoint_pin = PIN;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overlap_seen;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [20:0] output_sense_and_code, ripple_sense;
   logic high_side_on, low_side_on, discharge_on, regulation_good_flag, overvoltage_clamp;
   logic light_load_pulse_skip_select, irq;
   int err_count = 0, n_compared = 0, cyc = 0;
   int on_cnt = 0, off_cnt = 0, last_on = 0, min_off = 9999, n_rise = 0;

   always #5 core_clk = ~core_clk;

   // Device under test with shortened start-up and retry counts
   buck_seq_prot #(.REGULATION_GOOD_FLAG_CYC(PG), .RETRY_CYC(RT), .ONTIME_K(OK)) buck_seq_prot_i (
      .core_clk, .rst, .ce, .enable, .vin_present, .vcc_ok, .initial_setpoint_pin, .output_sense_and_code,
      .ripple_sense, .vin_volts, .low_side_over_limit, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .high_side_on, .low_side_on, .discharge_on, .regulation_good_flag,
      .overvoltage_clamp, .light_load_pulse_skip_select, .irq);

   power_stage_model power_stage_model_i (.core_clk, .rst, .high_side_on, .low_side_on, .level,
      .output_sense_and_code, .ripple_sense, .overlap_seen);

   // Measures on widths, off gaps and pulse starts; cuts a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      hs_d <= high_side_on;
      if (high_side_on && !hs_d) begin
         n_rise <= n_rise + 1;
         on_cnt <= 1;
         if (off_cnt < min_off) min_off <= off_cnt;
      end else if (high_side_on) on_cnt <= on_cnt + 1;
      if (!high_side_on && hs_d) begin
         last_on <= on_cnt;
         off_cnt <= 1;
      end else if (!high_side_on) off_cnt <= off_cnt + 1;
      if (cyc == 60000) begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Write cycle: address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int t;
      @(posedge core_clk);
      t = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         t++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 100);
      s_axi_bready <= 1'b0;
      chk_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   // Read cycle: data and response taken at the edge that shows rvalid
   task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int t;
      @(posedge core_clk);
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         t++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 100);
      s_axi_rready <= 1'b0;
      chk_word("rdata", e, s_axi_rdata);
      chk_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   task automatic wait_good(input int lim);
      int t;
      t = 0;
      while (regulation_good_flag !== 1'b1 && t < lim) begin
         @(posedge core_clk);
         t++;
      end
      chk_bit("good", 1'b1, regulation_good_flag);
   endtask

   // Clamp sets above 120 percent of sp and holds until the output is back under sp
   task automatic ov_check(input int sp);
      level <= 21'(sp * 13 / 10);
      tick(8);
      chk_bit("clamp", 1'b1, overvoltage_clamp);
      chk_bit("high side", 1'b0, high_side_on);
      chk_bit("low side", 1'b1, low_side_on);
      level <= 21'(sp * 11 / 10);
      tick(8);
      chk_bit("clamp", 1'b1, overvoltage_clamp);
      level <= 21'(sp * 9 / 10);
      tick(8);
      chk_bit("clamp", 1'b0, overvoltage_clamp);
   endtask

   // Main sequence
   initial begin
      int r0;
      tick(20);
      rst <= 1'b0;
      tick(4);
      chk_bit("skip", 1'b1, light_load_pulse_skip_select);
      chk_bit("discharge", 1'b1, discharge_on);
      axi_read(ADDR_CODE, 32'h0000_0032, RESP_OKAY);
      axi_read(ADDR_CTRL, 32'h0000_0009, RESP_OKAY);
      axi_read(8'h40, 32'h0000_0000, RESP_SLVERR);
      axi_write(8'h40, 32'h0000_0000, RESP_SLVERR);
      enable <= 1'b1;
      tick(300);
      chk_bit("good", 1'b0, regulation_good_flag);
      chk_bit("high side", 1'b0, high_side_on);
      chk_bit("discharge", 1'b0, discharge_on);
      vcc_ok <= 1'b1;
      tick(PG - 5);
      chk_bit("good", 1'b0, regulation_good_flag);
      wait_good(20);
      tick(12000);
      min_off = 9999;
      tick(300);
      chk_word("on width", OK / 20, last_on);
      chk_bit("off gap", 1'b1, min_off >= MIN_OFF_CYC);
      vin_volts <= 8'h28;
      tick(300);
      chk_word("on width", OK / 40, last_on);
      low_side_over_limit <= 1'b1;
      tick(20);
      r0 = n_rise;
      tick(100);
      chk_word("pulse starts", r0, n_rise);
      chk_bit("low side", 1'b1, low_side_on);
      low_side_over_limit <= 1'b0;
      tick(100);
      chk_bit("pulses resume", 1'b1, n_rise > r0);
      ov_check(700000);
      axi_write(ADDR_CODE, 32'h0000_0000, RESP_OKAY);
      axi_write(ADDR_CTRL, 32'h0000_0089, RESP_OKAY);
      ov_check(600000);
      axi_write(ADDR_CODE, 32'h0000_0064, RESP_OKAY);
      axi_read(ADDR_CODE, 32'h0000_0064, RESP_OKAY);
      ov_check(600000 + 9375 * 100);
      axi_write(ADDR_CTRL, 32'h0000_0009, RESP_OKAY);
      ov_check(700000);
      level <= NORM;
      axi_write(ADDR_IRQ_ST, 32'h0000_001F, RESP_OKAY);
      axi_write(ADDR_IRQ_MASK, 32'h0000_001F, RESP_OKAY);
      level <= LOW;
      tick(UV_DELAY_CYC - 100);
      r0 = n_rise;
      tick(80);
      chk_bit("switching", 1'b1, n_rise > r0);
      tick(40);
      chk_bit("high side", 1'b0, high_side_on);
      chk_bit("low side", 1'b0, low_side_on);
      axi_read(ADDR_IRQ_ST, 32'h0000_0012, RESP_OKAY);
      chk_bit("irq", 1'b1, irq);
      axi_write(ADDR_IRQ_ST, 32'h0000_001F, RESP_OKAY);
      tick(2);
      chk_bit("irq", 1'b0, irq);
      axi_read(ADDR_IRQ_ST, 32'h0000_0000, RESP_OKAY);
      axi_write(ADDR_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
      tick(2);
      chk_bit("irq", 1'b0, irq);
      level <= NORM;
      tick(RT * 4);
      chk_bit("high side", 1'b0, high_side_on);
      chk_bit("low side", 1'b0, low_side_on);
      enable <= 1'b0;
      tick(5);
      chk_bit("discharge", 1'b1, discharge_on);
      enable <= 1'b1;
      tick(PG - 5);
      chk_bit("good", 1'b0, regulation_good_flag);
      wait_good(20);
      tick(12000);
      axi_write(ADDR_CTRL, 32'h0000_0008, RESP_OKAY);
      level <= LOW;
      tick(UV_DELAY_CYC + 40);
      chk_bit("high side", 1'b0, high_side_on);
      chk_bit("low side", 1'b0, low_side_on);
      level <= NORM;
      wait_good(RT + PG + 200);
      axi_write(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      tick(2);
      chk_bit("skip", 1'b0, light_load_pulse_skip_select);
      chk_bit("overlap", 1'b0, overlap_seen);
      summarize();
   end
endmodule
